// *** hdl/dss_pkg.sv ***
package dss_pkg;

    // Register space
    localparam int unsigned DSS_ADDR_W      = 19;
    localparam int unsigned DSS_DATA_W      = 32;
    localparam logic [18:0] DSS_STATUS_OFS  = 19'h4_8000;

    // Field positions of device_status_straps
    localparam int unsigned DSS_POS_SRIO_ID     = 31;
    localparam int unsigned DSS_POS_HOST_ROLE   = 30;
    localparam int unsigned DSS_POS_TX_SWAP     = 29;
    localparam int unsigned DSS_POS_RX_SWAP     = 28;
    localparam int unsigned DSS_POS_CLK_MODE    = 27;
    localparam int unsigned DSS_POS_I2C_ROLE    = 26;
    localparam int unsigned DSS_POS_SRIO_BOOT   = 25;
    localparam int unsigned DSS_POS_I2C_PIN_SEL = 24;
    localparam int unsigned DSS_POS_I2C_SLAVE_ADDR_STRAP_LO   = 17;
    localparam int unsigned DSS_POS_I2C_INHIBIT = 16;
    localparam int unsigned DSS_POS_REF_FREQ_LO = 12;
    localparam int unsigned DSS_POS_RATE_LO     = 9;
    localparam int unsigned DSS_POS_MAC_READY   = 1;

    // Reset values
    localparam logic [31:0] DSS_RDATA_RST   = 32'h0000_0000;
    localparam logic [17:0] DSS_STRAPS_RST  = 18'h0_0000;

    typedef struct packed {
        logic       srio_id;
        logic       host_role;
        logic       tx_lane_swap;
        logic       rx_lane_swap;
        logic       clock_mode;
        logic       i2c_role;
        logic       srio_boot;
        logic       i2c_pin_sel;
        logic [3:0] i2c_slave_addr;
        logic       i2c_load_inhibit;
        logic [1:0] ref_freq_choice;
        logic [2:0] link_rate;
    } dss_straps_t;

    typedef struct packed {
        logic [18:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } dss_bus_req_t;

    typedef enum logic [1:0] {
        DSS_ST_CAPTURE,
        DSS_ST_WAIT_RDY,
        DSS_ST_START,
        DSS_ST_RUN
    } dss_state_t;

endpackage

// *** hdl/dss_strap_latch.sv ***
module dss_strap_latch
    import dss_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        capture,
    input  wire dss_straps_t pins,
    output dss_straps_t      held_r
);

    logic [17:0] pins_flat;
    logic [17:0] held_flat_r;

    assign pins_flat = pins;
    assign held_r    = held_flat_r;

    // Capture only on the single cycle after reset release; pins are don't-care later
    for (genvar i = 0; i < 18; i++) begin : g_bit
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                held_flat_r[i] <= DSS_STRAPS_RST[i];
            end else if (capture) begin
                held_flat_r[i] <= pins_flat[i];
            end
        end
    end

endmodule

// *** hdl/dss_read_port.sv ***
module dss_read_port
    import dss_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [18:0] addr,
    input  wire logic        rd,
    input  wire logic [31:0] status_word,
    output logic      [31:0] rdata_r
);

    logic        hit;
    logic [31:0] rdata_nxt;

    assign hit = (addr == DSS_STATUS_OFS);

    // Unmapped reads and idle cycles return zero so stale data never lingers
    always_comb begin
        rdata_nxt = DSS_RDATA_RST;
        if (rd && hit) begin
            rdata_nxt = status_word;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= DSS_RDATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

endmodule

// *** hdl/dss_top.sv ***
// How it works
// - Bit 31 holds captured device-id strap
// - Bit 30 holds captured host-role strap
// - Bits 29, 28 hold tx/rx lane-swap straps
// - Bit 27 holds captured clock-mode strap
// - Bit 26 holds captured I2C role strap
// - Bit 25 holds captured serial-boot strap
// - Bit 24 holds captured I2C pin-select strap
// - Bits 20:17 hold captured I2C slave address
// - Bit 16 holds captured I2C-load inhibit strap
// - Bits 13:12 hold captured clock-frequency straps
// - Bits 11:9 hold captured link-rate straps
// - Bit 1 sets once MAC is ready
// - EEPROM download starts only after ready
module dss_top
    import dss_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [18:0] bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [31:0] bus_rdata,
    input  wire dss_straps_t strap_pins,
    input  wire logic        mac_ready,
    output dss_straps_t      straps_held,
    output logic             straps_valid,
    output logic             pcie_mac_ready,
    output logic             eeprom_dl_start,
    output logic             boot_busy
);

    dss_bus_req_t bus_req;
    dss_state_t   state_r;
    dss_state_t   state_nxt;
    logic         capture;
    logic         straps_valid_r;
    logic         pcie_mac_ready_r;
    logic         eeprom_dl_start_r;
    logic         boot_busy_r;
    logic         eeprom_boot;
    logic [31:0]  status_word;
    logic [31:0]  bus_rdata_w;
    dss_straps_t  held_w;

    assign bus_req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

    // First cycle after reset release is the capture slot
    assign capture = (state_r == DSS_ST_CAPTURE);

    dss_strap_latch u_latch (
        .clk    (clk),
        .arst_n (arst_n),
        .capture(capture),
        .pins   (strap_pins),
        .held_r (held_w)
    );

    // EEPROM boot when neither serial boot nor I2C-load inhibit is strapped
    assign eeprom_boot = !held_w.srio_boot && !held_w.i2c_load_inhibit;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            DSS_ST_CAPTURE: begin
                state_nxt = DSS_ST_WAIT_RDY;
            end
            DSS_ST_WAIT_RDY: begin
                if (pcie_mac_ready_r) begin
                    state_nxt = eeprom_boot ? DSS_ST_START : DSS_ST_RUN;
                end
            end
            DSS_ST_START: begin
                state_nxt = DSS_ST_RUN;
            end
            DSS_ST_RUN: begin
                state_nxt = DSS_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= DSS_ST_CAPTURE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            straps_valid_r <= 1'b0;
        end else if (capture) begin
            straps_valid_r <= 1'b1;
        end
    end

    // Sticky until the next fundamental reset; nothing else can clear it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pcie_mac_ready_r <= 1'b0;
        end else if (mac_ready) begin
            pcie_mac_ready_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            eeprom_dl_start_r <= 1'b0;
        end else begin
            eeprom_dl_start_r <= (state_nxt == DSS_ST_START);
        end
    end

    // Busy tells boot agents that configuration must still wait
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_busy_r <= 1'b1;
        end else begin
            boot_busy_r <= (state_nxt != DSS_ST_RUN);
        end
    end

    always_comb begin
        status_word = DSS_RDATA_RST;
        status_word[DSS_POS_SRIO_ID]     = held_w.srio_id;
        status_word[DSS_POS_HOST_ROLE]   = held_w.host_role;
        status_word[DSS_POS_TX_SWAP]     = held_w.tx_lane_swap;
        status_word[DSS_POS_RX_SWAP]     = held_w.rx_lane_swap;
        status_word[DSS_POS_CLK_MODE]    = held_w.clock_mode;
        status_word[DSS_POS_I2C_ROLE]    = held_w.i2c_role;
        status_word[DSS_POS_SRIO_BOOT]   = held_w.srio_boot;
        status_word[DSS_POS_I2C_PIN_SEL] = held_w.i2c_pin_sel;
        status_word[DSS_POS_I2C_SLAVE_ADDR_STRAP_LO +: 4]   = held_w.i2c_slave_addr;
        status_word[DSS_POS_I2C_INHIBIT]      = held_w.i2c_load_inhibit;
        status_word[DSS_POS_REF_FREQ_LO +: 2] = held_w.ref_freq_choice;
        status_word[DSS_POS_RATE_LO +: 3]     = held_w.link_rate;
        status_word[DSS_POS_MAC_READY]        = pcie_mac_ready_r;
    end

    // Write strobe and data are deliberately not wired: the register is read-only
    dss_read_port u_rd (
        .clk        (clk),
        .arst_n     (arst_n),
        .addr       (bus_req.addr),
        .rd         (bus_req.rd),
        .status_word(status_word),
        .rdata_r    (bus_rdata_w)
    );

    assign bus_rdata       = bus_rdata_w;
    assign straps_held     = held_w;
    assign straps_valid    = straps_valid_r;
    assign pcie_mac_ready  = pcie_mac_ready_r;
    assign eeprom_dl_start = eeprom_dl_start_r;
    assign boot_busy       = boot_busy_r;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    logic status_rd;
    assign status_rd = bus_rd && (bus_addr == DSS_STATUS_OFS);

    property p_id_bit;
        status_rd |=> bus_rdata[31] == $past(held_w.srio_id);
    endproperty
    a_id_bit: assert property (p_id_bit)
        else $error("device-id bit mismatch");

    property p_host_bit;
        status_rd |=> bus_rdata[30] == $past(held_w.host_role);
    endproperty
    a_host_bit: assert property (p_host_bit)
        else $error("host-role bit mismatch");

    property p_swap_bits;
        status_rd |=> bus_rdata[29:28]
            == {$past(held_w.tx_lane_swap), $past(held_w.rx_lane_swap)};
    endproperty
    a_swap_bits: assert property (p_swap_bits)
        else $error("lane-swap bits mismatch");

    property p_clk_mode_bit;
        status_rd |=> bus_rdata[27] == $past(held_w.clock_mode);
    endproperty
    a_clk_mode_bit: assert property (p_clk_mode_bit)
        else $error("clock-mode bit mismatch");

    property p_i2c_role_bit;
        status_rd |=> bus_rdata[26] == $past(held_w.i2c_role);
    endproperty
    a_i2c_role_bit: assert property (p_i2c_role_bit)
        else $error("I2C role bit mismatch");

    property p_boot_bit;
        status_rd |=> bus_rdata[25] == $past(held_w.srio_boot);
    endproperty
    a_boot_bit: assert property (p_boot_bit)
        else $error("serial-boot bit mismatch");

    property p_pin_sel_bit;
        status_rd |=> bus_rdata[24] == $past(held_w.i2c_pin_sel);
    endproperty
    a_pin_sel_bit: assert property (p_pin_sel_bit)
        else $error("I2C pin-select bit mismatch");

    // The captured value must track the pins of the capture cycle, then freeze
    property p_sa_capture;
        capture |=> straps_held.i2c_slave_addr == $past(strap_pins.i2c_slave_addr)
            ##1 $stable(straps_held.i2c_slave_addr) [*4];
    endproperty
    a_sa_capture: assert property (p_sa_capture)
        else $error("slave address not captured or not held");

    property p_sa_field;
        status_rd |=> bus_rdata[20:17] == $past(held_w.i2c_slave_addr);
    endproperty
    a_sa_field: assert property (p_sa_field)
        else $error("slave address field mismatch");

    property p_inhibit_bit;
        status_rd |=> bus_rdata[16] == $past(held_w.i2c_load_inhibit);
    endproperty
    a_inhibit_bit: assert property (p_inhibit_bit)
        else $error("load-inhibit bit mismatch");

    property p_freq_field;
        status_rd |=> bus_rdata[13:12] == $past(held_w.ref_freq_choice);
    endproperty
    a_freq_field: assert property (p_freq_field)
        else $error("clock-frequency field mismatch");

    property p_rate_field;
        capture ##1 status_rd |=> bus_rdata[11:9] == $past(strap_pins.link_rate, 2);
    endproperty
    a_rate_field: assert property (p_rate_field)
        else $error("link-rate field does not show captured pins");

    property p_ready_sets;
        mac_ready |=> pcie_mac_ready ##1 pcie_mac_ready;
    endproperty
    a_ready_sets: assert property (p_ready_sets)
        else $error("ready flag not set or not sticky");

    property p_ready_read;
        status_rd |=> bus_rdata[1] == $past(pcie_mac_ready_r);
    endproperty
    a_ready_read: assert property (p_ready_read)
        else $error("ready bit read mismatch");

    property p_dl_after_ready;
        $rose(eeprom_dl_start) |-> $past(pcie_mac_ready_r) && eeprom_boot;
    endproperty
    a_dl_after_ready: assert property (p_dl_after_ready)
        else $error("EEPROM download started before ready");

    property p_dl_follows;
        (state_r == DSS_ST_WAIT_RDY) && pcie_mac_ready_r && eeprom_boot
            |=> eeprom_dl_start ##1 !eeprom_dl_start;
    endproperty
    a_dl_follows: assert property (p_dl_follows)
        else $error("EEPROM download pulse missing or too long");

    property p_busy_until_ready;
        !pcie_mac_ready_r |=> boot_busy;
    endproperty
    a_busy_until_ready: assert property (p_busy_until_ready)
        else $error("boot agents released before ready");

    property p_reserved_zero;
        ##1 (bus_rdata[23:21] == 3'h0) && (bus_rdata[15:14] == 2'h0)
            && (bus_rdata[8:0] & 9'h1FD) == 9'h000;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit reads nonzero");

    property p_write_ignored;
        bus_req.wr && !mac_ready && !capture |=> $stable(status_word);
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("write altered the status register");

    property p_unmapped_zero;
        bus_rd && (bus_addr != DSS_STATUS_OFS) |=> bus_rdata == 32'h0000_0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read returned data");

    property p_valid_after_capture;
        capture |=> straps_valid;
    endproperty
    a_valid_after_capture: assert property (p_valid_after_capture)
        else $error("straps not flagged valid after capture");

    // Later pin activity must never reach the captured copy
    property p_straps_frozen;
        !capture |=> $stable(straps_held);
    endproperty
    a_straps_frozen: assert property (p_straps_frozen)
        else $error("captured straps changed after capture");

    property p_ready_from_pin;
        $rose(pcie_mac_ready) |-> $past(mac_ready);
    endproperty
    a_ready_from_pin: assert property (p_ready_from_pin)
        else $error("ready flag set without MAC indication");

    property p_no_dl_before_ready;
        !pcie_mac_ready_r |=> !eeprom_dl_start;
    endproperty
    a_no_dl_before_ready: assert property (p_no_dl_before_ready)
        else $error("EEPROM download pulse while not ready");

    property p_busy_released;
        pcie_mac_ready_r && !eeprom_boot |=> !boot_busy;
    endproperty
    a_busy_released: assert property (p_busy_released)
        else $error("boot agents held off after ready");

    property p_rdata_idle_zero;
        !bus_rd |=> bus_rdata == 32'h0000_0000;
    endproperty
    a_rdata_idle_zero: assert property (p_rdata_idle_zero)
        else $error("read data present without a read");

    property p_cov_eeprom;
        eeprom_dl_start;
    endproperty
    c_cov_eeprom: cover property (p_cov_eeprom);

    property p_cov_srio_boot;
        (state_r == DSS_ST_RUN) && held_w.srio_boot && !eeprom_dl_start;
    endproperty
    c_cov_srio_boot: cover property (p_cov_srio_boot);

    property p_cov_poll;
        (status_rd && !pcie_mac_ready) ##2 (status_rd && pcie_mac_ready) ##1 bus_rdata[1];
    endproperty
    c_cov_poll: cover property (p_cov_poll);

    property p_cov_write;
        bus_wr ##2 status_rd;
    endproperty
    c_cov_write: cover property (p_cov_write);

endmodule

// *** verification/dss_boot_partner.sv ***
// Strap pins and MAC-ready source seen from outside the device
module dss_boot_partner
    import dss_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire dss_straps_t pattern,
    input  wire logic [7:0]  ready_delay,
    output dss_straps_t      strap_pins,
    output logic             mac_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 8'h00;
        end else if (cnt_r != 8'hff) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    // Pins flip one cycle after the capture edge, so a later re-sample shows up
    assign strap_pins = (cnt_r < 8'h02) ? pattern : ~pattern;
    // A single-cycle pulse is the harshest legal form of the ready indication
    assign mac_ready  = (cnt_r == ready_delay);
endmodule

// *** verification/device_strap_status_tb.sv ***
module device_strap_status_tb
    import dss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [18:0] bus_addr = 19'h0_0000;
    logic [31:0] bus_wdata = 32'h0000_0000;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    dss_straps_t pattern = 18'h0_0000;
    logic [7:0]  ready_delay = 8'hc8;
    dss_straps_t strap_pins;
    logic        mac_ready;
    dss_straps_t straps_held;
    logic        straps_valid;
    logic        pcie_mac_ready;
    logic        eeprom_dl_start;
    logic        boot_busy;
    int          num_errors = 0;
    int          comparisons = 0;

    always #20 clk = ~clk;

    dss_top dut (
        .clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .strap_pins(strap_pins), .mac_ready(mac_ready), .straps_held(straps_held),
        .straps_valid(straps_valid), .pcie_mac_ready(pcie_mac_ready),
        .eeprom_dl_start(eeprom_dl_start), .boot_busy(boot_busy)
    );

    dss_boot_partner partner (
        .clk(clk), .arst_n(arst_n), .pattern(pattern), .ready_delay(ready_delay),
        .strap_pins(strap_pins), .mac_ready(mac_ready)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] exp_word(input dss_straps_t s, input logic rdy);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[31]    = s.srio_id;
        w[30]    = s.host_role;
        w[29]    = s.tx_lane_swap;
        w[28]    = s.rx_lane_swap;
        w[27]    = s.clock_mode;
        w[26]    = s.i2c_role;
        w[25]    = s.srio_boot;
        w[24]    = s.i2c_pin_sel;
        w[20:17] = s.i2c_slave_addr;
        w[16]    = s.i2c_load_inhibit;
        w[13:12] = s.ref_freq_choice;
        w[11:9]  = s.link_rate;
        w[1]     = rdy;
        return w;
    endfunction

    task automatic do_reset(input dss_straps_t p, input logic [7:0] d);
        @(posedge clk);
        arst_n      <= 1'b0;
        pattern     <= p;
        ready_delay <= d;
        repeat (10) @(posedge clk);
        chk({28'h0, straps_valid, boot_busy, pcie_mac_ready, eeprom_dl_start}, 32'h0000_0004);
        arst_n <= 1'b1;
    endtask

    task automatic rd(input logic [18:0] a, output logic [31:0] d);
        @(posedge clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        d = bus_rdata;
    endtask

    task automatic wr(input logic [18:0] a, input logic [31:0] v);
        @(posedge clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= v;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask

    task automatic t_straps(input dss_straps_t p);
        logic [31:0] d;
        do_reset(p, 8'hc8);
        @(posedge clk);
        #1;
        chk({13'h0, straps_valid, straps_held}, {13'h0, 1'b1, p});
        repeat (3) @(posedge clk);
        rd(DSS_STATUS_OFS, d);
        chk(d, exp_word(p, 1'b0));
        chk(d, exp_word(p, 1'b0));
        wr(DSS_STATUS_OFS, 32'hffff_ffff);
        rd(DSS_STATUS_OFS, d);
        chk(d, exp_word(p, 1'b0));
        rd(19'h4_8004, d);
        chk(d, 32'h0000_0000);
        $display("test straps %h done", p);
    endtask

    task automatic t_boot(input dss_straps_t p, input logic eeprom);
        int r;
        int s;
        int b;
        int n;
        r = -1;
        s = -1;
        b = -1;
        n = 0;
        do_reset(p, 8'h06);
        for (int i = 1; i <= 30; i++) begin
            @(posedge clk);
            #1;
            if (pcie_mac_ready === 1'b1 && r < 0) r = i;
            if (eeprom_dl_start === 1'b1) begin
                n++;
                if (s < 0) s = i;
            end
            if (boot_busy === 1'b0 && b < 0) b = i;
        end
        chk(r, 7);
        chk(n, {31'h0, eeprom});
        if (eeprom) chk(s, r + 1);
        chk(b, eeprom ? r + 2 : r + 1);
        $display("test boot eeprom=%0d done", eeprom);
    endtask

    task automatic t_poll(input dss_straps_t p);
        logic [31:0] d;
        int polls;
        polls = 0;
        d = 32'h0000_0000;
        do_reset(p, 8'h28);
        while (d[1] !== 1'b1 && polls < 100) begin
            rd(DSS_STATUS_OFS, d);
            polls++;
        end
        chk({31'h0, polls > 5}, 32'h0000_0001);
        chk(d, exp_word(p, 1'b1));
        rd(DSS_STATUS_OFS, d);
        chk({d[1], boot_busy, eeprom_dl_start}, 3'b100);
        $display("test poll done");
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        t_straps(18'h2_aaaa);
        t_straps(18'h1_5555);
        t_boot(18'h0_0000, 1'b1);
        t_boot(18'h0_0200, 1'b1);
        t_boot(18'h0_0800, 1'b0);
        t_boot(18'h0_0020, 1'b0);
        t_poll(18'h0_1040);
        summarize();
    end

    // Whole run is well under 1000 cycles; allow ample margin
    initial begin
        #200_000;
        num_errors++;
        summarize();
    end
endmodule
